// ==== rtl/fam_regs.vh ====
`ifndef FAM_REGS_VH
`define FAM_REGS_VH

// Register byte addresses
`define FAM_A_LOW_TRIP      8'h00
`define FAM_A_HIGH_TRIP     8'h04
`define FAM_A_HYST          8'h08
`define FAM_A_FLOW_SETTLE   8'h0c
`define FAM_A_NOFLOW_RATIO  8'h10
`define FAM_A_NOFLOW_SETTLE 8'h14
`define FAM_A_CHOKE_RATIO   8'h18
`define FAM_A_CHOKE_SETTLE  8'h1c
`define FAM_A_SUPPLY_MIN    8'h20
`define FAM_A_SUPPLY_SETTLE 8'h24
`define FAM_A_REV_LIMIT     8'h28
`define FAM_A_REV_TIME      8'h2c
`define FAM_A_VALVE_MAX     8'h30
`define FAM_A_PAGE_COUNT    8'h34
`define FAM_A_ALARM         8'h40
`define FAM_A_ERROR         8'h44
`define FAM_A_WARNING       8'h48
`define FAM_A_PAGE_SEL      8'h4c

// Configuration register indices (byte address / 4)
`define FAM_I_LOW_TRIP      4'h0
`define FAM_I_HIGH_TRIP     4'h1
`define FAM_I_HYST          4'h2
`define FAM_I_FLOW_SETTLE   4'h3
`define FAM_I_NOFLOW_RATIO  4'h4
`define FAM_I_NOFLOW_SETTLE 4'h5
`define FAM_I_CHOKE_RATIO   4'h6
`define FAM_I_CHOKE_SETTLE  4'h7
`define FAM_I_SUPPLY_MIN    4'h8
`define FAM_I_SUPPLY_SETTLE 4'h9
`define FAM_I_REV_LIMIT     4'ha
`define FAM_I_REV_TIME      4'hb
`define FAM_I_VALVE_MAX     4'hc
`define FAM_I_PAGE_COUNT    4'hd
`define FAM_NUM_CFG         14
`define FAM_CFG_ADDR_TOP    8'h34

// Reset values of the configuration registers
`define FAM_RST_LOW_TRIP    16'h0000
`define FAM_RST_HIGH_TRIP   16'h7fff
`define FAM_RST_HYST        16'h0000
`define FAM_RST_SETTLE      16'h0000
`define FAM_RST_RATIO       16'h0000
`define FAM_RST_SUPPLY_MIN  16'h0000
`define FAM_RST_REV_LIMIT   16'h8000
`define FAM_RST_VALVE_MAX   16'hffff
`define FAM_RST_PAGE_COUNT  16'h0001

// Alarm word bit positions
`define FAM_AL_LOW_FLOW     0
`define FAM_AL_HIGH_FLOW    1
`define FAM_AL_NO_FLOW      2
`define FAM_AL_CHOKED       3
`define FAM_AL_BAD_PAGE     15
`define FAM_AL_BACKUP_MEM   23
`define FAM_AL_TEMP_FAIL    24
// Error word bit positions
`define FAM_ER_REVERSE      2
`define FAM_ER_INT_COMM     18
// Warning word bit position
`define FAM_WN_SUPPLY_LOW   27

// Valve open threshold: percent of maximum
`define FAM_VALVE_PCT       8'h46
`define FAM_PCT_FULL        8'h64
// Valve override selections
`define FAM_OVR_OFF         2'h1
`define FAM_OVR_PURGE       2'h2
// Ratio registers are fractions with this many bits
`define FAM_RATIO_FRAC      16

// Timebase of the settling counters
`define FAM_TICK_NS         1000000
`define FAM_CLK_NS          10

`endif

// ==== rtl/fam_persist.v ====
`timescale 1ns/1ps
// Persistence filter: flag flips only after its pending condition
// has held for more than limit ticks.
module fam_persist #(
  parameter CW = 16
) (
  input wire mclk,
  input wire srst,
  input wire ce,
  input wire tick,
  input wire inhibit,
  input wire set_cond,
  input wire clr_cond,
  input wire [CW-1:0] limit,
  output reg flag
);
  // Ticks the pending condition has held
  reg [CW-1:0] count;
  // Condition that would change the flag
  wire pending;

  assign pending = flag ? clr_cond : set_cond;

  // Count while pending, restart on lapse or inhibit
  always @(posedge mclk) begin
    if (srst) begin
      count <= {CW{1'b0}};
      flag <= 1'b0;
    end else if (ce) begin
      if (inhibit) begin
        // Held low while disabled
        count <= {CW{1'b0}};
        flag <= 1'b0;
      end else if (!pending) begin
        count <= {CW{1'b0}};
      end else if (tick) begin
        // limit+1 ticks means strictly longer than limit
        // At-or-above, so a smaller limit written mid-count is not missed
        if (count >= limit) begin
          flag <= ~flag;
          count <= {CW{1'b0}};
        end else begin
          count <= count + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// ==== rtl/fam_page.v ====
`timescale 1ns/1ps
// Process gas page selector with validity check
module fam_page #(
  parameter PW = 16
) (
  input wire mclk,
  input wire srst,
  input wire ce,
  input wire page_strobe,
  input wire [PW-1:0] page_id,
  input wire [PW-1:0] page_count,
  output reg [PW-1:0] page_sel,
  output reg page_bad
);
  // Valid identifiers lie below the page count
  wire id_ok;

  assign id_ok = (page_id < page_count);

  // Take a new page only when it is valid
  always @(posedge mclk) begin
    if (srst) begin
      page_sel <= {PW{1'b0}};
      page_bad <= 1'b0;
    end else if (ce && page_strobe) begin
      if (id_ok) begin
        page_sel <= page_id;
        page_bad <= 1'b0;
      end else begin
        // Old page stays selected
        page_bad <= 1'b1;
      end
    end
  end
endmodule

// ==== rtl/fam_monitor.v ====
`timescale 1ns/1ps
`include "fam_regs.vh"
module fam_monitor #(
  parameter DW = 16,
  // Clock cycles per settling-time tick (1 ms at 100 MHz)
  parameter TICK_CYCLES = `FAM_TICK_NS / `FAM_CLK_NS
) (
  input wire mclk,
  input wire srst,
  input wire ce,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Measurement and control inputs
  input wire [DW-1:0] flow,
  input wire flow_valid,
  input wire [DW-1:0] setpoint,
  input wire [DW-1:0] valve_pos,
  input wire [DW-1:0] supply_v,
  input wire [1:0] valve_override,
  input wire zeroing,
  input wire dev_alarms,
  input wire executing,
  input wire nv_write_fail,
  input wire temp_sens_ok,
  input wire comm_fault,
  input wire page_strobe,
  input wire [DW-1:0] page_id,
  // Status outputs
  output wire [31:0] alarm_status_word,
  output wire [31:0] error_status_word,
  output wire [31:0] warning_word,
  output reg backup_storage_in_use,
  output wire [DW-1:0] page_sel
);
  // Configuration registers
  reg [DW-1:0] cfg [0:`FAM_NUM_CFG-1];
  // Tick prescaler
  reg [31:0] pre_cnt;
  reg tick;
  // Sticky error latches
  reg reverse_rate_error;
  reg int_comm_error;
  // Filter outputs
  wire low_flag;
  wire high_flag;
  wire noflow_flag;
  wire choke_flag;
  wire supply_flag;
  wire reverse_flag;
  wire page_bad;
  // Named views of configuration
  wire [DW-1:0] rate_low_trip;
  wire [DW-1:0] rate_high_trip;
  wire [DW-1:0] hyst;
  wire [DW-1:0] reverse_rate_limit;
  wire [DW-1:0] reverse_persist_time;
  wire [DW-1:0] valve_max;
  // Comparison results
  wire signed [DW:0] flow_s;
  wire signed [DW:0] low_clr_lvl;
  wire signed [DW:0] high_clr_lvl;
  wire [2*DW-1:0] noflow_prod;
  wire [2*DW-1:0] choke_prod;
  wire [DW-1:0] noflow_lvl;
  wire [DW-1:0] choke_lvl;
  wire [DW+7:0] valve_scaled;
  wire [DW+7:0] valve_thresh;
  wire valve_open;
  wire valve_shut;
  wire noflow_below;
  wire noflow_above;
  wire choke_below;
  wire choke_above;
  wire ratio_inhibit;
  wire reverse_inhibit;
  wire cfg_hit;
  wire [3:0] cfg_idx;

  assign rate_low_trip = cfg[`FAM_I_LOW_TRIP];
  assign rate_high_trip = cfg[`FAM_I_HIGH_TRIP];
  assign hyst = cfg[`FAM_I_HYST];
  assign reverse_rate_limit = cfg[`FAM_I_REV_LIMIT];
  assign reverse_persist_time = cfg[`FAM_I_REV_TIME];
  assign valve_max = cfg[`FAM_I_VALVE_MAX];

  // Address decode for configuration space
  // Writes above the top index are dropped; the read-only words take no writes
  assign cfg_idx = reg_addr[5:2];
  assign cfg_hit = (reg_addr[1:0] == 2'h0) && (reg_addr <= `FAM_CFG_ADDR_TOP);

  // Reset value per configuration index
  function [DW-1:0] cfg_reset;
    input [3:0] idx;
    begin
      case (idx)
        `FAM_I_LOW_TRIP: cfg_reset = `FAM_RST_LOW_TRIP;
        `FAM_I_HIGH_TRIP: cfg_reset = `FAM_RST_HIGH_TRIP;
        `FAM_I_HYST: cfg_reset = `FAM_RST_HYST;
        `FAM_I_NOFLOW_RATIO: cfg_reset = `FAM_RST_RATIO;
        `FAM_I_CHOKE_RATIO: cfg_reset = `FAM_RST_RATIO;
        `FAM_I_SUPPLY_MIN: cfg_reset = `FAM_RST_SUPPLY_MIN;
        `FAM_I_REV_LIMIT: cfg_reset = `FAM_RST_REV_LIMIT;
        `FAM_I_VALVE_MAX: cfg_reset = `FAM_RST_VALVE_MAX;
        `FAM_I_PAGE_COUNT: cfg_reset = `FAM_RST_PAGE_COUNT;
        default: cfg_reset = `FAM_RST_SETTLE;
      endcase
    end
  endfunction

  // One write port per configuration word
  genvar gi;
  generate
    for (gi = 0; gi < `FAM_NUM_CFG; gi = gi + 1) begin : g_cfg
      // Index of this word at the width of the address field
      localparam [3:0] IDX = gi;
      always @(posedge mclk) begin
        if (srst) begin
          cfg[gi] <= cfg_reset(IDX);
        end else if (ce && reg_wr && cfg_hit && (cfg_idx == IDX)) begin
          // Upper bus bits are dropped
          cfg[gi] <= reg_wdata[DW-1:0];
        end
      end
    end
  endgenerate

  // Read data the cycle after the strobe; unmapped reads zero
  always @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= 32'h00000000;
    end else if (ce) begin
      if (!reg_rd) begin
        // Data stands only in the cycle after the strobe
        reg_rdata <= 32'h00000000;
      end else if (cfg_hit) begin
        reg_rdata <= {{(32-DW){1'b0}}, cfg[cfg_idx]};
      end else begin
        case (reg_addr)
          `FAM_A_ALARM: reg_rdata <= alarm_status_word;
          `FAM_A_ERROR: reg_rdata <= error_status_word;
          `FAM_A_WARNING: reg_rdata <= warning_word;
          `FAM_A_PAGE_SEL: reg_rdata <= {{(32-DW){1'b0}}, page_sel};
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Settling timebase; a free tick makes timing granular to one tick
  // Limitation: the first tick lands a full period after reset
  always @(posedge mclk) begin
    if (srst) begin
      pre_cnt <= 32'h00000000;
      tick <= 1'b0;
    end else if (ce) begin
      if (pre_cnt == TICK_CYCLES - 1) begin
        pre_cnt <= 32'h00000000;
        tick <= 1'b1;
      end else begin
        pre_cnt <= pre_cnt + 32'h00000001;
        tick <= 1'b0;
      end
    end
  end

  // Flow is signed; sums widened to avoid wrap at the ends of range
  assign flow_s = {flow[DW-1], flow};
  assign low_clr_lvl = {rate_low_trip[DW-1], rate_low_trip} + {hyst[DW-1], hyst};
  assign high_clr_lvl = {rate_high_trip[DW-1], rate_high_trip} - {hyst[DW-1], hyst};

  // Ratio times setpoint, ratio as an unsigned fraction
  assign noflow_prod = cfg[`FAM_I_NOFLOW_RATIO] * setpoint;
  assign choke_prod = cfg[`FAM_I_CHOKE_RATIO] * setpoint;
  assign noflow_lvl = noflow_prod[2*DW-1:`FAM_RATIO_FRAC];
  assign choke_lvl = choke_prod[2*DW-1:`FAM_RATIO_FRAC];
  // Negative flow always counts as below a ratio level
  assign noflow_below = flow[DW-1] | ({1'b0, flow[DW-2:0]} < noflow_lvl);
  assign noflow_above = !flow[DW-1] && (flow > noflow_lvl);
  assign choke_below = flow[DW-1] | ({1'b0, flow[DW-2:0]} < choke_lvl);
  assign choke_above = !flow[DW-1] && (flow > choke_lvl);

  // Valve against 70% of maximum, by cross-multiplying
  assign valve_scaled = valve_pos * `FAM_PCT_FULL;
  assign valve_thresh = valve_max * `FAM_VALVE_PCT;
  assign valve_open = valve_scaled > valve_thresh;
  assign valve_shut = valve_scaled < valve_thresh;

  // Ratio diagnostics disabled conditions
  assign ratio_inhibit = !flow_valid || (setpoint == {DW{1'b0}}) || (valve_override == `FAM_OVR_OFF);
  // Reverse diagnostic disabled conditions
  assign reverse_inhibit = (valve_override == `FAM_OVR_PURGE) || zeroing || dev_alarms || !executing;

  // Low flow alarm
  fam_persist #(.CW(DW)) u_low (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .tick(tick),
    .inhibit(!flow_valid),
    .set_cond(flow_s < $signed({rate_low_trip[DW-1], rate_low_trip})),
    .clr_cond(flow_s > low_clr_lvl),
    .limit(cfg[`FAM_I_FLOW_SETTLE]),
    .flag(low_flag)
  );

  // High flow alarm
  fam_persist #(.CW(DW)) u_high (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .tick(tick),
    .inhibit(!flow_valid),
    .set_cond(flow_s > $signed({rate_high_trip[DW-1], rate_high_trip})),
    .clr_cond(flow_s < high_clr_lvl),
    .limit(cfg[`FAM_I_FLOW_SETTLE]),
    .flag(high_flag)
  );

  // No flow alarm
  fam_persist #(.CW(DW)) u_noflow (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .tick(tick),
    .inhibit(ratio_inhibit),
    .set_cond(noflow_below && valve_open),
    .clr_cond(noflow_above || valve_shut),
    .limit(cfg[`FAM_I_NOFLOW_SETTLE]),
    .flag(noflow_flag)
  );

  // Choked flow alarm
  fam_persist #(.CW(DW)) u_choke (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .tick(tick),
    .inhibit(ratio_inhibit),
    .set_cond(choke_below && valve_open),
    .clr_cond(choke_above || valve_shut),
    .limit(cfg[`FAM_I_CHOKE_SETTLE]),
    .flag(choke_flag)
  );

  // Supply low warning
  fam_persist #(.CW(DW)) u_supply (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .tick(tick),
    .inhibit(1'b0),
    .set_cond(supply_v < cfg[`FAM_I_SUPPLY_MIN]),
    .clr_cond(supply_v > cfg[`FAM_I_SUPPLY_MIN]),
    .limit(cfg[`FAM_I_SUPPLY_SETTLE]),
    .flag(supply_flag)
  );

  // Reverse flow detector; clears only under reverse_inhibit, latched below
  fam_persist #(.CW(DW)) u_reverse (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .tick(tick),
    .inhibit(reverse_inhibit),
    .set_cond(flow_s < $signed({reverse_rate_limit[DW-1], reverse_rate_limit})),
    .clr_cond(1'b0),
    .limit(reverse_persist_time),
    .flag(reverse_flag)
  );

  // Gas page selection
  fam_page #(.PW(DW)) u_page (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .page_strobe(page_strobe),
    .page_id(page_id),
    .page_count(cfg[`FAM_I_PAGE_COUNT]),
    .page_sel(page_sel),
    .page_bad(page_bad)
  );

  // Sticky latches: only reset clears them
  // No software clear exists, so a set can never be lost to one
  always @(posedge mclk) begin
    if (srst) begin
      reverse_rate_error <= 1'b0;
      int_comm_error <= 1'b0;
      backup_storage_in_use <= 1'b0;
    end else if (ce) begin
      if (reverse_flag) begin
        reverse_rate_error <= 1'b1;
      end
      if (comm_fault && flow_valid) begin
        // Link fault checked only with valid flow
        int_comm_error <= 1'b1;
      end
      if (nv_write_fail) begin
        // Switch to backup storage for good
        backup_storage_in_use <= 1'b1;
      end
    end
  end

  // Status words assembled from flag flip-flops
  // Bit 24 is combinational, so a sensor fault shows at once
  assign alarm_status_word = (32'h00000001 << `FAM_AL_LOW_FLOW) & {32{low_flag}}
    | (32'h00000001 << `FAM_AL_HIGH_FLOW) & {32{high_flag}}
    | (32'h00000001 << `FAM_AL_NO_FLOW) & {32{noflow_flag}}
    | (32'h00000001 << `FAM_AL_CHOKED) & {32{choke_flag}}
    | (32'h00000001 << `FAM_AL_BAD_PAGE) & {32{page_bad}}
    | (32'h00000001 << `FAM_AL_BACKUP_MEM) & {32{backup_storage_in_use}}
    | (32'h00000001 << `FAM_AL_TEMP_FAIL) & {32{!temp_sens_ok}};
  assign error_status_word = (32'h00000001 << `FAM_ER_REVERSE) & {32{reverse_rate_error}}
    | (32'h00000001 << `FAM_ER_INT_COMM) & {32{int_comm_error}};
  assign warning_word = (32'h00000001 << `FAM_WN_SUPPLY_LOW) & {32{supply_flag}};
endmodule

// ==== tb/fam_monitor_props.sv ====
`timescale 1ns/1ps
// Port-level checker for the status monitor
module fam_monitor_props #(
  parameter DW = 16
) (
  input wire mclk,
  input wire srst,
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire flow_valid,
  input wire [DW-1:0] setpoint,
  input wire [1:0] valve_override,
  input wire zeroing,
  input wire dev_alarms,
  input wire executing,
  input wire nv_write_fail,
  input wire temp_sens_ok,
  input wire comm_fault,
  input wire page_strobe,
  input wire [DW-1:0] page_id,
  input wire [31:0] alarm_status_word,
  input wire [31:0] error_status_word,
  input wire [31:0] warning_word,
  input wire backup_storage_in_use,
  input wire [DW-1:0] page_sel
);
  // One clock domain, so one default clock and reset
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // Read data only in the cycle after a strobe
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data not idle");
  a_alarm_word_read: assert property ($past(reg_rd && reg_addr == 8'h40) |-> reg_rdata == $past(alarm_status_word))
    else $error("alarm read mismatch");
  a_error_word_read: assert property ($past(reg_rd && reg_addr == 8'h44) |-> reg_rdata == $past(error_status_word))
    else $error("error read mismatch");
  a_warn_word_read: assert property ($past(reg_rd && reg_addr == 8'h48) |-> reg_rdata == $past(warning_word))
    else $error("warning read mismatch");
  a_temp_fail_bit: assert property (alarm_status_word[24] == !temp_sens_ok) else $error("sensor bit wrong");
  a_backup_set: assert property (nv_write_fail |=> alarm_status_word[23] && backup_storage_in_use)
    else $error("backup flag not set");
  a_backup_sticky: assert property (backup_storage_in_use |=> backup_storage_in_use) else $error("backup dropped");
  a_reverse_sticky: assert property (error_status_word[2] |=> error_status_word[2]) else $error("error 2 dropped");
  a_comm_sticky: assert property (error_status_word[18] |=> error_status_word[18]) else $error("error 18 dropped");
  a_comm_latch: assert property (comm_fault && flow_valid |=> error_status_word[18]) else $error("link error missed");
  // Inhibit must stand three cycles to cover the filter and the latch
  a_reverse_guard: assert property ((valve_override == 2'h2 || zeroing || dev_alarms || !executing) [*3]
    |-> !$rose(error_status_word[2])) else $error("error 2 set while inhibited");
  a_flow_inhibit: assert property (!flow_valid |=> alarm_status_word[1:0] == 2'b00) else $error("flow alarm inhibited");
  a_ratio_inhibit: assert property ((!flow_valid || setpoint == 0 || valve_override == 2'h1)
    |=> alarm_status_word[3:2] == 2'b00) else $error("ratio alarm inhibited");
  a_page_kept: assert property (page_strobe ##1 alarm_status_word[15] |-> $stable(page_sel))
    else $error("page changed on bad id");
  a_page_taken: assert property (page_strobe ##1 !alarm_status_word[15] |-> page_sel == $past(page_id))
    else $error("page not taken");
endmodule

bind fam_monitor fam_monitor_props #(.DW(DW)) u_props (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flow_valid(flow_valid), .setpoint(setpoint),
  .valve_override(valve_override), .zeroing(zeroing), .dev_alarms(dev_alarms), .executing(executing),
  .nv_write_fail(nv_write_fail), .temp_sens_ok(temp_sens_ok), .comm_fault(comm_fault), .page_strobe(page_strobe),
  .page_id(page_id), .alarm_status_word(alarm_status_word), .error_status_word(error_status_word),
  .warning_word(warning_word),
  .backup_storage_in_use(backup_storage_in_use), .page_sel(page_sel));

// ==== tb/fam_monitor_tb.sv ====
`timescale 1ns/1ps
// Self-checking bench for the status monitor
module fam_monitor_tb;
  // Reset and settings tables, index 13 down to 0
  localparam [223:0] RST = {16'h0001, 16'hffff, 16'h0000, 16'h8000, 16'h0, 16'h0, 16'h0,
    16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h7fff, 16'h0000};
  localparam [223:0] CFG = {16'h0004, 16'h03e8, 16'h0001, 16'h0000, 16'h0001, 16'h01f4, 16'h0001,
    16'hc000, 16'h0001, 16'h8000, 16'h0002, 16'h0014, 16'h03e8, 16'h0064};
  reg mclk, srst, ce, reg_wr, reg_rd, flow_valid, zeroing, dev_alarms, executing;
  reg nv_write_fail, temp_sens_ok, comm_fault, page_strobe, rd_pend;
  reg [7:0] reg_addr;
  reg [31:0] reg_wdata, rv;
  reg [15:0] flow, setpoint, valve_pos, supply_v, page_id;
  reg [1:0] valve_override;
  wire [31:0] reg_rdata, alarm_w, error_w, warn_w;
  wire backup;
  wire [15:0] page_sel;
  integer num_errors, comparisons, i;
  reg [31:0] exp_q[$]; // Expected read data, oldest first

  // Short tick keeps the settling waits small
  fam_monitor #(.DW(16), .TICK_CYCLES(4)) dut (.mclk(mclk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flow(flow),
    .flow_valid(flow_valid), .setpoint(setpoint), .valve_pos(valve_pos), .supply_v(supply_v),
    .valve_override(valve_override), .zeroing(zeroing), .dev_alarms(dev_alarms), .executing(executing),
    .nv_write_fail(nv_write_fail), .temp_sens_ok(temp_sens_ok), .comm_fault(comm_fault),
    .page_strobe(page_strobe), .page_id(page_id), .alarm_status_word(alarm_w), .error_status_word(error_w),
    .warning_word(warn_w), .backup_storage_in_use(backup), .page_sel(page_sel));

  // Free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Compare and count
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask

  // Verdict and end of run
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask

  // Bus cycles: extra edge after each so a strobe is never set twice in one step
  task wr(input [7:0] a, input [31:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
    end
  endtask
  // Longest settle for n ticks at four cycles a tick, plus register stages
  task wait_ticks(input integer n);
    repeat ((n + 1) * 4 + 3) @(posedge mclk);
  endtask
  task pg(input [15:0] id);
    begin
      page_id <= id;
      page_strobe <= 1'b1;
      @(posedge mclk);
      page_strobe <= 1'b0;
      @(posedge mclk);
    end
  endtask

  // Monitor: read data is due one cycle after each strobe
  always @(posedge mclk) begin
    if (rd_pend) chk(reg_rdata, exp_q.pop_front());
    rd_pend <= reg_rd;
  end

  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge mclk);
    num_errors = num_errors + 1;
    test_done;
  end

  initial begin
    num_errors = 0; comparisons = 0; rd_pend = 0; srst = 1; ce = 1; reg_wr = 0; reg_rd = 0;
    reg_addr = 0; reg_wdata = 0; flow = 16'h01f4; flow_valid = 0; setpoint = 0; valve_pos = 0;
    // Not executing yet, so random settings cannot latch a reverse error
    supply_v = 16'h03e8; valve_override = 0; zeroing = 0; dev_alarms = 0; executing = 0;
    nv_write_fail = 0; temp_sens_ok = 1; comm_fault = 0; page_strobe = 0; page_id = 0;
    rv = $urandom(17);
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    // Reset values, unmapped and read-only places
    for (i = 0; i < 14; i = i + 1) rd({i[5:0], 2'b00}, {16'h0, RST[i*16 +: 16]});
    rd(8'h38, 32'h0);
    wr(8'h40, 32'hffff);
    rd(8'h40, 32'h0);
    $display("reset value test done");
    // Random write and read back, then working settings
    for (i = 0; i < 14; i = i + 1) begin
      rv = $urandom;
      wr({i[5:0], 2'b00}, rv);
      rd({i[5:0], 2'b00}, {16'h0, rv[15:0]});
      wr({i[5:0], 2'b00}, {16'h0, CFG[i*16 +: 16]});
    end
    $display("register test done");
    // Low flow: not early, restart on lapse, set, hysteresis, inhibit; then high flow set and hysteresis
    flow_valid <= 1'b1;
    flow <= 16'd50;
    repeat (6) @(posedge mclk);
    flow <= 16'd130;
    @(posedge mclk);
    flow <= 16'd50;
    repeat (6) @(posedge mclk);
    rd(8'h40, 32'h0);
    wait_ticks(2);
    rd(8'h40, 32'h1);
    flow <= 16'd110;
    wait_ticks(2);
    rd(8'h40, 32'h1);
    flow <= 16'd130;
    wait_ticks(2);
    rd(8'h40, 32'h0);
    flow <= 16'd50;
    wait_ticks(2);
    flow_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    rd(8'h40, 32'h0);
    flow_valid <= 1'b1;
    flow <= 16'd1100;
    wait_ticks(2);
    rd(8'h40, 32'h2);
    flow <= 16'd990;
    wait_ticks(2);
    rd(8'h40, 32'h2);
    flow <= 16'd970;
    wait_ticks(2);
    rd(8'h40, 32'h0);
    $display("flow limit test done");
    // Ratio alarms against 70 percent of a valve maximum of 1000
    flow <= 16'd600;
    setpoint <= 16'h03e8;
    valve_pos <= 16'd800;
    wait_ticks(2);
    rd(8'h40, 32'h8);
    flow <= 16'd400;
    for (i = 0; i < 3; i = i + 1) begin
      wait_ticks(1);
      rd(8'h40, 32'hc);
      setpoint <= (i == 0) ? 16'h0 : 16'h03e8;
      valve_override <= (i == 1) ? 2'h1 : 2'h0;
      flow_valid <= (i != 2);
      repeat (2) @(posedge mclk);
      rd(8'h40, 32'h0);
      setpoint <= 16'h03e8;
      valve_override <= 2'h0;
      flow_valid <= 1'b1;
    end
    wait_ticks(1);
    valve_pos <= 16'd600;
    wait_ticks(1);
    rd(8'h40, 32'h0);
    $display("ratio alarm test done");
    // Reverse flow under each inhibit, then set and sticky
    flow <= 16'hfffb;
    for (i = 0; i < 4; i = i + 1) begin
      valve_override <= (i == 0) ? 2'h2 : 2'h0;
      zeroing <= (i == 1);
      dev_alarms <= (i == 2);
      executing <= (i != 3);
      wait_ticks(2);
      rd(8'h44, 32'h0);
    end
    executing <= 1'b1;
    wait_ticks(2);
    rd(8'h44, 32'h4);
    flow <= 16'd500;
    executing <= 1'b0;
    wait_ticks(2);
    rd(8'h44, 32'h4);
    comm_fault <= 1'b1;
    flow_valid <= 1'b0;
    repeat (3) @(posedge mclk);
    rd(8'h44, 32'h4);
    flow_valid <= 1'b1;
    @(posedge mclk);
    comm_fault <= 1'b0;
    repeat (2) @(posedge mclk);
    rd(8'h44, 32'h40004);
    $display("error word test done");
    // Supply low warning both ways
    supply_v <= 16'd400;
    wait_ticks(1);
    rd(8'h48, 32'h08000000);
    supply_v <= 16'd600;
    wait_ticks(1);
    rd(8'h48, 32'h0);
    // Page selection with four valid pages
    pg(16'd2);
    rd(8'h4c, 32'h2);
    rd(8'h40, 32'h0);
    pg(16'd4);
    rd(8'h4c, 32'h2);
    rd(8'h40, 32'h8000);
    pg(16'd3);
    rd(8'h4c, 32'h3);
    rd(8'h40, 32'h0);
    $display("supply and page test done");
    // Sensor failure and storage failover
    temp_sens_ok <= 1'b0;
    @(posedge mclk);
    rd(8'h40, 32'h01000000);
    nv_write_fail <= 1'b1;
    @(posedge mclk);
    nv_write_fail <= 1'b0;
    @(posedge mclk);
    chk({31'h0, backup}, 32'h1);
    temp_sens_ok <= 1'b1;
    rd(8'h40, 32'h00800000);
    // Only a reset clears the sticky bits
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    rd(8'h44, 32'h0);
    chk({31'h0, backup}, 32'h0);
    $display("status and reset test done");
    repeat (3) @(posedge mclk);
    test_done;
  end
endmodule
